// File: hw/tx_clkout_packet_config_regs.sv
`timescale 1ns/1ps
`include "txcpr_defs.svh"
module tx_clkout_packet_config_regs (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [4:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   input wire logic crcResultValid,
   input wire logic crcResultPass,
   input wire logic rxAddrValid,
   input wire logic [7:0] rxAddr,
   output logic rxAddrAccept,
   output logic clkOut,
   output txcpr_pkg::txcpr_cfg_s cfg
);
   txcpr_pkg::txcpr_regs_s state_ff;
   txcpr_pkg::txcpr_regs_s nxt_state;
   logic divClk;

   function automatic logic addr_ok(input logic [1:0] mode, input logic [7:0] node, input logic [7:0] a);
      logic ok;
      ok = 1'b0;
      unique case (mode)
         `TXCPR_FILT_OFF: ok = 1'b1;
         `TXCPR_FILT_NODE: ok = (a == node);
         `TXCPR_FILT_ZERO: ok = (a == node) || (a == `TXCPR_BCAST_ZERO);
         default: ok = (a == node) || (a == `TXCPR_BCAST_ZERO) || (a == `TXCPR_BCAST_ONES);
      endcase
      return ok;
   endfunction

   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] mask);
      return (wd & mask) | (old & ~mask);
   endfunction

   always_comb begin
      nxt_state = state_ff;
      if (regWrEn) begin
         unique case (regAddr)
            `TXCPR_A_TXP: nxt_state.txp = merge(state_ff.txp, regWrData, `TXCPR_WMASK_TXP);
            `TXCPR_A_OSC: nxt_state.osc = merge(state_ff.osc, regWrData, `TXCPR_WMASK_OSC);
            `TXCPR_A_PKL: nxt_state.pkl = regWrData;
            `TXCPR_A_NODE: nxt_state.node = regWrData;
            `TXCPR_A_FMT: nxt_state.fmt = merge(state_ff.fmt, regWrData, `TXCPR_WMASK_FMT);
            `TXCPR_A_FIFO: nxt_state.fifo = merge(state_ff.fifo, regWrData, `TXCPR_WMASK_FIFO);
            default: ;
         endcase
      end
      if (crcResultValid) begin
         nxt_state.crcPass = crcResultPass;
      end
      if (regRdEn) begin
         unique case (regAddr)
            `TXCPR_A_TXP: nxt_state.rdData = state_ff.txp;
            `TXCPR_A_OSC: nxt_state.rdData = state_ff.osc;
            `TXCPR_A_PKL: nxt_state.rdData = state_ff.pkl;
            `TXCPR_A_NODE: nxt_state.rdData = state_ff.node;
            `TXCPR_A_FMT: nxt_state.rdData = {state_ff.fmt[`TXCPR_F_UPPER], state_ff.crcPass};
            `TXCPR_A_FIFO: nxt_state.rdData = state_ff.fifo;
            default: nxt_state.rdData = '0;
         endcase
      end
      if (rxAddrValid) begin
         nxt_state.addrAccept = addr_ok(state_ff.fmt[`TXCPR_F_FILT], state_ff.node, rxAddr);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff.txp <= `TXCPR_RST_TXP;
         state_ff.osc <= `TXCPR_RST_OSC;
         state_ff.pkl <= `TXCPR_RST_PKL;
         state_ff.node <= `TXCPR_RST_NODE;
         state_ff.fmt <= `TXCPR_RST_FMT;
         state_ff.fifo <= `TXCPR_RST_FIFO;
         state_ff.crcPass <= 1'b0;
         state_ff.rdData <= '0;
         state_ff.addrAccept <= 1'b0;
      end else if (clkEn) begin
         state_ff <= nxt_state;
      end
   end

   txcpr_clk_div u_div (
      .core_clk(core_clk),
      .rst(rst),
      .clkEn(clkEn),
      .enable(state_ff.osc[`TXCPR_F_CLKON]),
      .divCode(state_ff.osc[`TXCPR_F_CLKDIV]),
      .clkOut(divClk)
   );

   assign regRdData = state_ff.rdData;
   assign rxAddrAccept = state_ff.addrAccept;
   assign clkOut = divClk;
   always_comb begin
      cfg.interpCutoff = state_ff.txp[`TXCPR_F_CUTOFF];
      cfg.txPower = state_ff.txp[`TXCPR_F_POWER];
      cfg.clkoutOn = state_ff.osc[`TXCPR_F_CLKON];
      cfg.clkoutDiv = state_ff.osc[`TXCPR_F_CLKDIV];
      cfg.manchesterOn = state_ff.pkl[`TXCPR_F_MANCH];
      cfg.payloadLength = state_ff.pkl[`TXCPR_F_LEN];
      cfg.nodeAddress = state_ff.node;
      cfg.variableFormat = state_ff.fmt[`TXCPR_F_VARFMT];
      cfg.preambleSize = state_ff.fmt[`TXCPR_F_PREAMB];
      cfg.whiteningOn = state_ff.fmt[`TXCPR_F_WHITE];
      cfg.crcOn = state_ff.fmt[`TXCPR_F_CRCON];
      cfg.addrFilter = state_ff.fmt[`TXCPR_F_FILT];
      cfg.crcAutoClearOff = state_ff.fifo[`TXCPR_F_AUTOCLR];
      cfg.fifoStbyRead = state_ff.fifo[`TXCPR_F_STBY];
   end
endmodule

// File: hw/txcpr_clk_div.sv
`timescale 1ns/1ps
`include "txcpr_defs.svh"
module txcpr_clk_div (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic enable,
   input wire logic [4:0] divCode,
   output logic clkOut
);
   txcpr_pkg::txcpr_div_s state_ff;
   txcpr_pkg::txcpr_div_s nxt_state;
   always_comb begin
      nxt_state = state_ff;
      if (!enable) begin
         nxt_state.cnt = '0;
         nxt_state.clkOut = 1'b0;
      end else if (divCode == `TXCPR_DIV_BYPASS) begin
         nxt_state.cnt = '0;
         nxt_state.clkOut = ~state_ff.clkOut;
      end else if ((state_ff.cnt + `TXCPR_DIV_ONE) >= {1'b0, divCode}) begin
         // half period of code cycles gives divide by twice the code
         nxt_state.cnt = '0;
         nxt_state.clkOut = ~state_ff.clkOut;
      end else begin
         nxt_state.cnt = state_ff.cnt + `TXCPR_DIV_ONE;
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff <= '0;
      end else if (clkEn) begin
         state_ff <= nxt_state;
      end
   end
   assign clkOut = state_ff.clkOut;
endmodule

// File: include/txcpr_defs.svh
`ifndef TXCPR_DEFS_SVH
`define TXCPR_DEFS_SVH
`define TXCPR_ADDR_W 5
`define TXCPR_A_TXP 5'h1a
`define TXCPR_A_OSC 5'h1b
`define TXCPR_A_PKL 5'h1c
`define TXCPR_A_NODE 5'h1d
`define TXCPR_A_FMT 5'h1e
`define TXCPR_A_FIFO 5'h1f
`define TXCPR_RST_TXP 8'h72
`define TXCPR_RST_OSC 8'hbc
`define TXCPR_RST_PKL 8'h00
`define TXCPR_RST_NODE 8'h00
`define TXCPR_RST_FMT 8'h48
`define TXCPR_RST_FIFO 8'h00
`define TXCPR_WMASK_TXP 8'hfe
`define TXCPR_WMASK_OSC 8'hfc
`define TXCPR_WMASK_FMT 8'hfe
`define TXCPR_WMASK_FIFO 8'hc0
`define TXCPR_FILT_OFF 2'h0
`define TXCPR_FILT_NODE 2'h1
`define TXCPR_FILT_ZERO 2'h2
`define TXCPR_BCAST_ZERO 8'h00
`define TXCPR_BCAST_ONES 8'hff
`define TXCPR_DIV_BYPASS 5'h00
`define TXCPR_DIV_ONE 6'h01
`define TXCPR_F_CUTOFF 7:4
`define TXCPR_F_POWER 3:1
`define TXCPR_F_CLKON 7
`define TXCPR_F_CLKDIV 6:2
`define TXCPR_F_MANCH 7
`define TXCPR_F_LEN 6:0
`define TXCPR_F_VARFMT 7
`define TXCPR_F_PREAMB 6:5
`define TXCPR_F_WHITE 4
`define TXCPR_F_CRCON 3
`define TXCPR_F_FILT 2:1
`define TXCPR_F_UPPER 7:1
`define TXCPR_F_AUTOCLR 7
`define TXCPR_F_STBY 6
`endif

// File: include/txcpr_pkg.sv
package txcpr_pkg;
   typedef struct packed {
      logic [3:0] interpCutoff;
      logic [2:0] txPower;
      logic clkoutOn;
      logic [4:0] clkoutDiv;
      logic manchesterOn;
      logic [6:0] payloadLength;
      logic [7:0] nodeAddress;
      logic variableFormat;
      logic [1:0] preambleSize;
      logic whiteningOn;
      logic crcOn;
      logic [1:0] addrFilter;
      logic crcAutoClearOff;
      logic fifoStbyRead;
   } txcpr_cfg_s;
   typedef struct packed {
      logic [7:0] txp;
      logic [7:0] osc;
      logic [7:0] pkl;
      logic [7:0] node;
      logic [7:0] fmt;
      logic [7:0] fifo;
      logic crcPass;
      logic [7:0] rdData;
      logic addrAccept;
   } txcpr_regs_s;
   typedef struct packed {
      logic [5:0] cnt;
      logic clkOut;
   } txcpr_div_s;
endpackage

// File: verif/tx_clkout_packet_config_regs_bench.sv
`timescale 1ns/1ps
module tx_clkout_packet_config_regs_bench;
   logic core_clk, rst, clkEn, crcResultValid, crcResultPass, rxAddrValid, rxAddrAccept, clkOut, crcp, b;
   logic regWrEn, regRdEn;
   logic [4:0] regAddr;
   logic [7:0] regWrData, regRdData, rxAddr, q, x;
   txcpr_pkg::txcpr_cfg_s cfg;
   logic [7:0] sh [6] = '{8'h72, 8'hbc, 8'h00, 8'h00, 8'h48, 8'h00};
   logic [7:0] wm [6] = '{8'hfe, 8'hfc, 8'hff, 8'hff, 8'hfe, 8'hc0};
   int dv [3] = '{0, 3, 8};
   int err_count, comparisons, seed, n, i;
   tx_clkout_packet_config_regs uut (.*);
   txcpr_host host (.*);
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic complete_run;
      if (err_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d, q);
      if (a >= 5'h1a)
         sh[a - 5'h1a] = (d & wm[a - 5'h1a]) | (sh[a - 5'h1a] & ~wm[a - 5'h1a]);
   endtask
   task automatic rdc(input logic [4:0] a);
      host.xfer(1'b0, a, 8'h00, q);
      chk(q, a < 5'h1a ? 8'h00 : sh[a - 5'h1a] | {7'h00, a == 5'h1e && crcp});
   endtask
   task automatic pulse(input logic c, input logic p, input logic [7:0] v);
      @(posedge core_clk) #1;
      {crcResultValid, rxAddrValid, crcResultPass, rxAddr} = {c, !c, p, v};
      @(posedge core_clk) #1;
      {crcResultValid, rxAddrValid} = 2'h0;
   endtask
   initial begin
      {rst, clkEn, crcResultValid, crcResultPass, rxAddrValid, rxAddr, crcp} = {2'h3, 12'h000};
      seed = 11034;
      repeat (12) @(posedge core_clk);
      #1 rst = 1'b0;
      for (i = 24; i < 32; i++)
         rdc(5'(i));
      for (i = 0; i < 30; i++) begin
         n = 25 + $unsigned($random(seed)) % 7;
         wr(5'(n), 8'($random(seed)));
         rdc(5'(n));
      end
      clkEn = 1'b0;
      host.xfer(1'b1, 5'h1d, 8'haa, q);
      clkEn = 1'b1;
      rdc(5'h1d);
      for (i = 1; i >= 0; i--) begin
         pulse(1'b1, i[0], 8'h00);
         crcp = i[0];
         rdc(5'h1e);
      end
      wr(5'h1d, 8'h5a);
      for (i = 0; i < 16; i++) begin
         if (i % 4 == 0)
            wr(5'h1e, 8'h48 | 8'(i / 2));
         x = (i % 4 == 3) ? 8'($random(seed)) : (i % 4 == 0 ? 8'h5a : {8{i[1]}});
         pulse(1'b0, 1'b0, x);
         chk({7'h00, rxAddrAccept}, {7'h00, i < 4 || x == 8'h5a || (i > 7 && x == 8'h00) || (i > 11 && x == 8'hff)});
      end
      for (i = 0; i < 4; i++) begin
         wr(5'h1b, i == 3 ? 8'h0c : 8'h80 | 8'(dv[i] << 2));
         repeat (70) @(posedge core_clk) #1;
         q = 8'h00;
         for (n = 0; n < 24; n++) begin
            b = clkOut;
            @(posedge core_clk) #1;
            q += 8'(b !== clkOut);
         end
         chk(q, i == 3 ? 8'h00 : (dv[i] == 0 ? 8'h18 : 8'(24 / dv[i])));
      end
      complete_run;
   end
endmodule
bind tx_clkout_packet_config_regs txcpr_assertions sva (.*);

// File: verif/txcpr_assertions.sv
`timescale 1ns/1ps
module txcpr_assertions (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic regWrEn,
   input wire logic [4:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic rxAddrValid,
   input wire logic [7:0] rxAddr,
   input wire logic rxAddrAccept,
   input wire logic clkOut,
   input txcpr_pkg::txcpr_cfg_s cfg
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic [4:0] wa;
   logic [7:0] pd;
   logic rx;
   assign wa = (clkEn && regWrEn) ? regAddr : 5'h00;
   assign rx = clkEn && rxAddrValid;
   always_ff @(posedge core_clk) pd <= regWrData;
   property p_txp; wa == 5'h1a |=> cfg[37:31] == pd[7:1]; endproperty
   a_txp: assert property (p_txp) else $error("bad tx fields");
   property p_osc; wa == 5'h1b |=> cfg[30:25] == pd[7:2]; endproperty
   a_osc: assert property (p_osc) else $error("bad clock fields");
   property p_pkl; wa == 5'h1c |=> cfg[24:17] == pd; endproperty
   a_pkl: assert property (p_pkl) else $error("bad length fields");
   property p_node; wa == 5'h1d |=> cfg[16:9] == pd; endproperty
   a_node: assert property (p_node) else $error("bad node");
   property p_fmt; wa == 5'h1e |=> cfg[8:2] == pd[7:1]; endproperty
   a_fmt: assert property (p_fmt) else $error("bad format fields");
   property p_fifo; wa == 5'h1f |=> cfg[1:0] == pd[7:6]; endproperty
   a_fifo: assert property (p_fifo) else $error("bad fifo fields");
   property p_rej; rx && cfg[3:2] != 2'h0 && rxAddr != cfg[16:9] && (cfg[3:2] == 2'h1 || rxAddr != 8'h00)
      && (cfg[3:2] != 2'h3 || rxAddr != 8'hff) |=> !rxAddrAccept; endproperty
   a_rej: assert property (p_rej) else $error("bad accept");
   property p_off; (!cfg[30] && clkEn) [*2] |-> !clkOut; endproperty
   a_off: assert property (p_off) else $error("clock out active");
   c_fmt: cover property (wa == 5'h1e);
   c_acc: cover property (rx && cfg[3:2] == 2'h3);
   c_clk: cover property ($rose(clkOut));
endmodule

// File: verif/txcpr_host.sv
`timescale 1ns/1ps
module txcpr_host (
   input wire logic core_clk,
   input wire logic [7:0] regRdData,
   output logic regWrEn,
   output logic regRdEn,
   output logic [4:0] regAddr,
   output logic [7:0] regWrData
);
   initial {regWrEn, regRdEn, regAddr, regWrData} = 15'h0000;
   // one byte per access; address and data scrambled once released
   task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge core_clk) #1;
      regAddr = a;
      regWrData = d;
      regWrEn = w;
      regRdEn = !w;
      @(posedge core_clk) #1;
      q = regRdData;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = ~a;
      regWrData = ~d;
   endtask
endmodule
